// File: hdl/rx_descriptor_status_writeback.sv
`timescale 1ns/10ps
`default_nettype none
module rx_descriptor_status_writeback
   import rx_desc_pkg::*;
(
   // clock and reset
   input  wire logic        clock,
   input  wire logic        reset,
   // control
   input  wire logic        enable,
   input  wire logic        pollDemand,
   input  wire logic        passBadFrame,
   input  wire logic [31:0] listBase,
   // receive word stream
   input  wire logic        rxValid,
   input  wire logic [31:0] rxData,
   input  wire logic        rxLast,
   input  wire logic [1:0]  rxLastBytes,
   output logic             rxReady,
   // per-frame indications, sampled with the last word; phyRxError is gathered over the whole frame
   input  wire logic        crcError,
   input  wire logic        runtFrame,
   input  wire logic        multicastHit,
   input  wire logic        ipCsumErr,
   input  wire logic        tcpCsumErr,
   input  wire logic        udpCsumErr,
   input  wire logic        sourcePort1,
   input  wire logic        sourcePort2,
   input  wire logic        phyRxError,
   // host memory master
   output logic             memReq,
   output logic             memWrite,
   output logic [31:0]      memAddr,
   output logic [31:0]      memWdata,
   input  wire logic        memAck,
   input  wire logic [31:0] memRdata,
   // status
   output logic             ownerWait,
   output logic             frameDone
);

   dma_state_type state;
   logic [31:0] descAddr;
   logic [31:0] bufAddr;
   logic [31:0] nextAddr;
   logic [10:0] bufSize;
   logic        endRing;
   logic [31:0] offset;
   logic        descFirst;
   logic        frameOpen;
   logic        wordLast;
   logic [13:0] byteCount;
   logic        phyErrSeen;
   logic        crcSeen;
   logic        runtSeen;
   logic        mcastSeen;
   logic        ipSeen;
   logic        tcpSeen;
   logic        udpSeen;
   logic        port1Seen;
   logic        port2Seen;
   logic [31:0] next_status;
   logic        rxTake;
   logic        memDone;
   logic        frameClear;
   logic        dropRunt;
   logic        bufFull;
   logic        tooLong;
   logic [13:0] wordBytes;

   assign rxTake  = rxValid && rxReady;
   assign memDone = memReq && memAck;
   // a runt caught while pass-bad-frame is off is silently dropped
   assign dropRunt = runtSeen && !passBadFrame;
   assign frameClear = (state == RX_WRITE) && memDone && wordLast;
   assign bufFull = offset >= {21'h0, bufSize};
   assign tooLong = byteCount > MAX_FRAME_BYTES;
   assign wordBytes = (rxLast && (rxLastBytes != 2'h0)) ? {12'h000, rxLastBytes}
                                                         : WORD_BYTES[13:0];

   // status word composed in one piece
   always_comb begin
      next_status = STATUS_RESET;
      next_status[OWN_BIT] = 1'b0;
      next_status[FIRST_DESC_BIT] = descFirst;
      next_status[LAST_DESC_BIT] = wordLast;
      next_status[PHY_RX_ERROR_BIT] = phyErrSeen;
      if (wordLast) begin
         next_status[IP_CSUM_BIT]  = ipSeen;
         next_status[TCP_CSUM_BIT] = tcpSeen;
         next_status[UDP_CSUM_BIT] = udpSeen;
         next_status[ERROR_SUMMARY_BIT] = crcSeen || tooLong || runtSeen;
         next_status[MULTICAST_BIT] = mcastSeen;
         next_status[PORT1_BIT] = port1Seen;
         next_status[PORT2_BIT] = port2Seen;
         next_status[TOO_LONG_BIT] = tooLong;
         next_status[RUNT_BIT] = runtSeen;
         next_status[CRC_ERROR_BIT] = crcSeen;
         next_status[LENGTH_MSB:0] = tooLong && (byteCount > LENGTH_FIELD_MAX)
                                     ? LENGTH_FIELD_MAX[LENGTH_MSB:0]
                                     : byteCount[LENGTH_MSB:0];
      end
   end

   // frame accumulation; cleared as the frame's final status is launched
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         byteCount <= 14'h0000;
         crcSeen   <= 1'b0;
         runtSeen  <= 1'b0;
         mcastSeen <= 1'b0;
         ipSeen    <= 1'b0;
         tcpSeen   <= 1'b0;
         udpSeen   <= 1'b0;
         port1Seen <= 1'b0;
         port2Seen <= 1'b0;
      end else if (frameClear) begin
         byteCount <= 14'h0000;
         crcSeen   <= 1'b0;
         runtSeen  <= 1'b0;
         mcastSeen <= 1'b0;
         ipSeen    <= 1'b0;
         tcpSeen   <= 1'b0;
         udpSeen   <= 1'b0;
         port1Seen <= 1'b0;
         port2Seen <= 1'b0;
      end else if (rxTake) begin
         // saturate so a giant frame cannot wrap below the limit
         if (byteCount < 14'h3ff0) begin
            byteCount <= byteCount + wordBytes;
         end
         if (rxLast) begin
            crcSeen   <= crcError;
            runtSeen  <= runtFrame;
            mcastSeen <= multicastHit;
            ipSeen    <= ipCsumErr;
            tcpSeen   <= tcpCsumErr;
            udpSeen   <= udpCsumErr;
            port1Seen <= sourcePort1;
            port2Seen <= sourcePort2;
         end
      end
   end

   // sticky phy error, a new error wins over the clear
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         phyErrSeen <= 1'b0;
      end else if (frameClear) begin
         phyErrSeen <= phyRxError;
      end else if (frameOpen || rxTake) begin
         phyErrSeen <= phyErrSeen || phyRxError;
      end
   end

   // descriptor walk and memory traffic
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state     <= IDLE;
         descAddr  <= 32'h0000_0000;
         bufAddr   <= 32'h0000_0000;
         nextAddr  <= 32'h0000_0000;
         bufSize   <= 11'h000;
         endRing   <= 1'b0;
         offset    <= 32'h0000_0000;
         descFirst <= 1'b0;
         frameOpen <= 1'b0;
         wordLast  <= 1'b0;
         rxReady   <= 1'b0;
         memReq    <= 1'b0;
         memWrite  <= 1'b0;
         memAddr   <= 32'h0000_0000;
         memWdata  <= 32'h0000_0000;
         ownerWait <= 1'b0;
         frameDone <= 1'b0;
      end else begin
         frameDone <= 1'b0;
         if (memDone) begin
            memReq <= 1'b0;
         end
         case (state)
            IDLE: begin
               if (enable) begin
                  descAddr <= listBase;
                  memReq   <= 1'b1;
                  memWrite <= 1'b0;
                  memAddr  <= listBase + STATUS_WORD_OFFSET;
                  state    <= RD_STAT;
               end
            end
            RD_STAT: begin
               if (memDone) begin
                  if (memRdata[OWN_BIT]) begin
                     memReq  <= 1'b1;
                     memAddr <= descAddr + CONTROL_WORD_OFFSET;
                     state   <= RD_CTRL;
                  end else begin
                     ownerWait <= 1'b1;
                     state     <= OWN_WAIT;
                  end
               end
            end
            OWN_WAIT: begin
               // descriptor still with the host: wait for a poll
               if (!enable) begin
                  ownerWait <= 1'b0;
                  state     <= IDLE;
               end else if (pollDemand) begin
                  ownerWait <= 1'b0;
                  memReq    <= 1'b1;
                  memAddr   <= descAddr + STATUS_WORD_OFFSET;
                  state     <= RD_STAT;
               end
            end
            RD_CTRL: begin
               if (memDone) begin
                  bufSize <= memRdata[BUF_SIZE_MSB:0];
                  endRing <= memRdata[END_OF_RING_BIT];
                  memReq  <= 1'b1;
                  memAddr <= descAddr + BUFFER_ADDR_OFFSET;
                  state   <= RD_BUF;
               end
            end
            RD_BUF: begin
               if (memDone) begin
                  bufAddr <= memRdata;
                  memReq  <= 1'b1;
                  memAddr <= descAddr + NEXT_DESC_OFFSET;
                  state   <= RD_NEXT;
               end
            end
            RD_NEXT: begin
               if (memDone) begin
                  nextAddr <= memRdata;
                  if (bufSize == 11'h000) begin
                     state <= ADVANCE;
                  end else begin
                     offset    <= 32'h0000_0000;
                     descFirst <= !frameOpen;
                     rxReady   <= 1'b1;
                     state     <= RX_WAIT;
                  end
               end
            end
            RX_WAIT: begin
               if (rxTake) begin
                  rxReady   <= 1'b0;
                  memReq    <= 1'b1;
                  memWrite  <= 1'b1;
                  memAddr   <= bufAddr + offset;
                  memWdata  <= rxData;
                  offset    <= offset + WORD_BYTES;
                  wordLast  <= rxLast;
                  frameOpen <= 1'b1;
                  state     <= RX_WRITE;
               end
            end
            RX_WRITE: begin
               if (memDone) begin
                  if (wordLast && dropRunt) begin
                     // runt dropped, buffer reused; earlier buffers are lost
                     offset    <= 32'h0000_0000;
                     descFirst <= 1'b1;
                     frameOpen <= 1'b0;
                     wordLast  <= 1'b0;
                     memWrite  <= 1'b0;
                     rxReady   <= 1'b1;
                     state     <= RX_WAIT;
                  end else if (wordLast || bufFull) begin
                     memReq   <= 1'b1;
                     memWrite <= 1'b1;
                     memAddr  <= descAddr + STATUS_WORD_OFFSET;
                     memWdata <= next_status;
                     if (wordLast) begin
                        frameOpen <= 1'b0;
                     end
                     state <= WB_STAT;
                  end else begin
                     memWrite <= 1'b0;
                     rxReady  <= 1'b1;
                     state    <= RX_WAIT;
                  end
               end
            end
            WB_STAT: begin
               if (memDone) begin
                  memWrite  <= 1'b0;
                  frameDone <= wordLast;
                  wordLast  <= 1'b0;
                  state     <= ADVANCE;
               end
            end
            ADVANCE: begin
               descAddr <= endRing ? listBase : nextAddr;
               if (!enable) begin
                  state <= IDLE;
               end else begin
                  memReq   <= 1'b1;
                  memWrite <= 1'b0;
                  memAddr  <= (endRing ? listBase : nextAddr) + STATUS_WORD_OFFSET;
                  state    <= RD_STAT;
               end
            end
            default: begin
               state <= IDLE;
            end
         endcase
      end
   end

endmodule // rx_descriptor_status_writeback
`default_nettype wire

// File: pkg/rx_desc_pkg.sv
package rx_desc_pkg;
   // descriptor word offsets from the descriptor base, and the data word size, in bytes
   localparam logic [31:0] STATUS_WORD_OFFSET  = 32'h0000_0000;
   localparam logic [31:0] CONTROL_WORD_OFFSET = 32'h0000_0004;
   localparam logic [31:0] BUFFER_ADDR_OFFSET  = 32'h0000_0008;
   localparam logic [31:0] NEXT_DESC_OFFSET    = 32'h0000_000c;
   localparam logic [31:0] WORD_BYTES          = 32'h0000_0004;
   // status word fields
   localparam int OWN_BIT          = 31;
   localparam int FIRST_DESC_BIT   = 30;
   localparam int LAST_DESC_BIT    = 29;
   localparam int IP_CSUM_BIT      = 28;
   localparam int TCP_CSUM_BIT     = 27;
   localparam int UDP_CSUM_BIT     = 26;
   localparam int ERROR_SUMMARY_BIT = 25;
   localparam int MULTICAST_BIT    = 24;
   localparam int PORT1_BIT        = 20;
   localparam int PORT2_BIT        = 21;
   localparam int PHY_RX_ERROR_BIT = 19;
   localparam int TOO_LONG_BIT     = 18;
   localparam int RUNT_BIT         = 17;
   localparam int CRC_ERROR_BIT    = 16;
   localparam int LENGTH_MSB       = 10;
   // control word fields
   localparam int END_OF_RING_BIT  = 25;
   localparam int BUF_SIZE_MSB     = 10;
   // frame length limits and status word reset value
   localparam logic [13:0] MAX_FRAME_BYTES = 14'h05ee;
   localparam logic [13:0] LENGTH_FIELD_MAX = 14'h07ff;
   localparam logic [31:0] STATUS_RESET    = 32'h0000_0000;
   typedef enum logic [3:0] {
      IDLE     = 4'h0,
      RD_STAT  = 4'h1,
      RD_CTRL  = 4'h2,
      RD_BUF   = 4'h3,
      RD_NEXT  = 4'h4,
      OWN_WAIT = 4'h5,
      RX_WAIT  = 4'h6,
      RX_WRITE = 4'h7,
      WB_STAT  = 4'h8,
      ADVANCE  = 4'h9
   } dma_state_type;
endpackage

// File: tb/host_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_mem_model (
   // pacing
   input  wire logic        clock,
   input  wire logic        slow,
   // memory slave
   input  wire logic        memReq,
   input  wire logic        memWrite,
   input  wire logic [31:0] memAddr,
   input  wire logic [31:0] memWdata,
   output logic             memAck,
   output logic [31:0]      memRdata
);
   logic [31:0] mem [0:4095];
   logic [1:0]  waitCount = 2'h0;
   logic [31:0] lastRdata = 32'h0000_0000;
   // slow mode stalls every request for two cycles
   assign memAck = memReq && (!slow || waitCount == 2'h2);
   assign memRdata = (memAck && !memWrite) ? mem[memAddr[13:2]] : ~lastRdata;
   always @(posedge clock) begin
      waitCount <= (memReq && !memAck) ? waitCount + 2'h1 : 2'h0;
      if (memAck && memWrite) mem[memAddr[13:2]] <= memWdata;
      if (memAck && !memWrite) lastRdata <= memRdata;
   end
endmodule // host_mem_model
`default_nettype wire

// File: tb/rx_desc_chk.sv
`timescale 1ns/10ps
`default_nettype none
module rx_desc_chk (
   // clock and reset
   input wire logic        clock,
   input wire logic        reset,
   // receive stream
   input wire logic        rxValid,
   input wire logic [31:0] rxData,
   input wire logic        rxReady,
   // memory master and status
   input wire logic        memReq,
   input wire logic        memWrite,
   input wire logic [31:0] memWdata,
   input wire logic        memAck,
   input wire logic        ownerWait,
   input wire logic        frameDone
);
   logic dataPending;
   logic statusWrite;
   // a write with no taken word behind it can only be a write-back
   assign statusWrite = memReq && memWrite && !dataPending;
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         dataPending <= 1'b0;
      end else if (rxValid && rxReady) begin
         dataPending <= 1'b1;
      end else if (memReq && memAck && memWrite) begin
         dataPending <= 1'b0;
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   own_clear_a: assert property (statusWrite |-> !memWdata[31])
      else $error("write-back keeps ownership");
   summary_or_a: assert property (statusWrite && memWdata[29] |->
      memWdata[25] == |memWdata[18:16]) else $error("error summary wrong");
   reserved_port_a: assert property (statusWrite |-> memWdata[23:22] == 2'b00)
      else $error("reserved port bits set");
   long_flag_a: assert property (statusWrite && memWdata[29] |->
      memWdata[18] == (memWdata[10:0] > 11'd1518)) else $error("too long flag wrong");
   ready_drop_a: assert property (rxValid && rxReady |=> !rxReady)
      else $error("ready held after take");
   data_write_a: assert property (rxValid && rxReady |=>
      memReq && memWrite && memWdata == $past(rxData)) else $error("word not written");
   done_pulse_a: assert property (statusWrite && memAck && memWdata[29] |=> frameDone)
      else $error("no done after last write-back");
   owned_idle_a: assert property (ownerWait |-> !rxReady)
      else $error("ready while host owns");
   cover property (statusWrite && memAck && memWdata[29]);
   cover property (statusWrite && memAck && !memWdata[29]);
   cover property (ownerWait);
endmodule // rx_desc_chk
bind rx_descriptor_status_writeback rx_desc_chk u_chk (
   .clock(clock), .reset(reset), .rxValid(rxValid), .rxData(rxData), .rxReady(rxReady),
   .memReq(memReq), .memWrite(memWrite), .memWdata(memWdata), .memAck(memAck),
   .ownerWait(ownerWait), .frameDone(frameDone)
);
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin \
   samples_checked++; \
   if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp); \
   end \
end
module tb_top;
   logic        clock, reset, enable, pollDemand, passBadFrame, slow;
   logic        rxValid, rxLast, rxReady, memReq, memWrite, memAck, ownerWait, frameDone;
   logic [1:0]  rxLastBytes;
   // msb first: phy, port2, port1, udp, tcp, ip, multicast, runt, crc
   logic [8:0]  flags;
   logic [31:0] rxData, memAddr, memWdata, memRdata;
   int          n_mismatch = 0;
   int          samples_checked = 0;
   rx_descriptor_status_writeback u_dut (
      .clock(clock), .reset(reset), .enable(enable), .pollDemand(pollDemand),
      .passBadFrame(passBadFrame), .listBase(32'h0000_0000), .rxValid(rxValid),
      .rxData(rxData), .rxLast(rxLast), .rxLastBytes(rxLastBytes), .rxReady(rxReady),
      .crcError(flags[0]), .runtFrame(flags[1]), .multicastHit(flags[2]),
      .ipCsumErr(flags[3]), .tcpCsumErr(flags[4]), .udpCsumErr(flags[5]),
      .sourcePort1(flags[6]), .sourcePort2(flags[7]), .phyRxError(flags[8]),
      .memReq(memReq), .memWrite(memWrite), .memAddr(memAddr), .memWdata(memWdata),
      .memAck(memAck), .memRdata(memRdata), .ownerWait(ownerWait), .frameDone(frameDone)
   );
   host_mem_model u_host (
      .clock(clock), .slow(slow), .memReq(memReq), .memWrite(memWrite), .memAddr(memAddr),
      .memWdata(memWdata), .memAck(memAck), .memRdata(memRdata)
   );
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   task automatic putDesc(input int i, input logic [31:0] st, ct, bf, nx);
      u_host.mem[i] = st;
      u_host.mem[i + 1] = ct;
      u_host.mem[i + 2] = bf;
      u_host.mem[i + 3] = nx;
   endtask
   function automatic logic [31:0] expStat(input logic f, l, input logic [10:0] len,
                                           input logic ph);
      logic tl;
      tl = len > 11'd1518;
      if (!l) return {1'b0, f, 1'b0, 9'h000, ph, 19'h00000};
      return {1'b0, f, 1'b1, flags[3], flags[4], flags[5], flags[0] | flags[1] | tl, flags[2],
              2'b00, flags[7], flags[6], ph, tl, flags[1], flags[0], 5'h00, len};
   endfunction
   task automatic sendFrame(input int n, input logic [1:0] lb);
      int k;
      for (int i = 0; i < n; i++) begin
         @(negedge clock);
         rxValid = 1'b1;
         rxData = 32'h5a5a_0000 + 32'(i);
         rxLast = (i == n - 1);
         rxLastBytes = lb;
         k = 0;
         while (rxReady !== 1'b1 && k < 100) begin
            @(negedge clock);
            k++;
         end
         `CHK(rxReady, 1'b1)
      end
      @(negedge clock);
      rxValid = 1'b0;
      rxLast = 1'b0;
      rxData = ~rxData;
      // phy error only during reception; left high it would mark the next frame
      flags[8] = 1'b0;
   endtask
   // bounded wait for the done pulse (sel 0) or for owner wait (sel 1)
   task automatic waitHigh(input bit sel);
      int k;
      k = 0;
      while ((sel ? ownerWait : frameDone) !== 1'b1 && k < 300) begin
         @(negedge clock);
         k++;
      end
      `CHK(sel ? ownerWait : frameDone, 1'b1)
   endtask
   task automatic testBasic;
      flags = 9'h07d;
      sendFrame(2, 2'h2);
      waitHigh(1'b0);
      `CHK(u_host.mem[0], expStat(1'b1, 1'b1, 11'd6, 1'b0))
      `CHK(u_host.mem[1025], 32'h5a5a_0001)
   endtask
   // zero-size buffer, two-descriptor frame, slow host
   task automatic testChain;
      slow = 1'b1;
      passBadFrame = 1'b1;
      flags = 9'h182;
      sendFrame(3, 2'h0);
      waitHigh(1'b0);
      `CHK(u_host.mem[4], 32'h8000_0000)
      `CHK(u_host.mem[8], expStat(1'b1, 1'b0, 11'd0, 1'b1))
      `CHK(u_host.mem[12], expStat(1'b0, 1'b1, 11'd12, 1'b1))
      slow = 1'b0;
   endtask
   // wrap to the host-owned head, then an over-length frame
   task automatic testWrap;
      waitHigh(1'b1);
      `CHK(rxReady, 1'b0)
      putDesc(0, 32'h8000_0000, 32'h0000_05f0, 32'h0000_1000, 32'h0000_0010);
      pollDemand = 1'b1;
      flags = 9'h000;
      @(negedge clock);
      pollDemand = 1'b0;
      sendFrame(380, 2'h3);
      waitHigh(1'b0);
      `CHK(u_host.mem[0], expStat(1'b1, 1'b1, 11'd1519, 1'b0))
   endtask
   // runt dropped with pass-bad-frame off; the next frame reuses the buffer
   task automatic testRunt;
      waitHigh(1'b1);
      putDesc(8, 32'h8000_0000, 32'h0000_0004, 32'h0000_2000, 32'h0000_0030);
      passBadFrame = 1'b0;
      pollDemand = 1'b1;
      flags = 9'h002;
      @(negedge clock);
      pollDemand = 1'b0;
      sendFrame(1, 2'h0);
      flags = 9'h000;
      repeat (4) @(negedge clock);
      `CHK(u_host.mem[8], 32'h8000_0000)
      sendFrame(1, 2'h0);
      waitHigh(1'b0);
      `CHK(u_host.mem[8], expStat(1'b1, 1'b1, 11'd4, 1'b0))
   endtask
   task automatic end_sim;
      $display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      reset = 1'b1;
      {enable, pollDemand, passBadFrame, rxValid, rxLast, slow} = 6'b100000;
      rxData = 32'h0000_0000;
      rxLastBytes = 2'h0;
      flags = 9'h000;
      putDesc(0, 32'h8000_0000, 32'h0000_0010, 32'h0000_1000, 32'h0000_0010);
      putDesc(4, 32'h8000_0000, 32'h0000_0000, 32'h0000_1800, 32'h0000_0020);
      putDesc(8, 32'h8000_0000, 32'h0000_0004, 32'h0000_2000, 32'h0000_0030);
      putDesc(12, 32'h8000_0000, 32'h0200_0008, 32'h0000_2400, 32'h0000_0040);
      repeat (6) @(negedge clock);
      reset = 1'b0;
      testBasic();
      testChain();
      testWrap();
      testRunt();
      end_sim();
   end
   // the whole run needs well under 2000 cycles
   initial begin
      #20000;
      n_mismatch++;
      end_sim();
   end
endmodule // tb_top
`default_nettype wire
